// file: logic/operand_field_and_ea_decoder.sv
// Holds the operand field and effective address decoder of the execute stage.
// Assumes instr_i, pc_i and src_reg_val_i are stable in the cycle they are presented.
// Notes on behaviour
// - 12-bit displacement: sign-extend, double, add PC
// - Register branch target is PC plus register
// - Zero-extend immediate for test, and, or, xor
// - Sign-extend immediate for move, add, compare-equal
// - Trap immediate zero-extended then times four
// - Opcode bits select meaning of operand fields
// - n format: bits 11-8 name destination
// - m format: bits 11-8 name source
`timescale 1ns/1ps
module operand_field_and_ea_decoder #(
	parameter int DATA_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic [op_decode_pkg::WORD_W-1:0] instr_i,
	input wire logic [DATA_W-1:0] pc_i,
	input wire logic [DATA_W-1:0] src_reg_val_i,
	output logic valid_o,
	output op_decode_pkg::fmt_t fmt_o,
	output logic [3:0] dst_reg_o,
	output logic dst_reg_valid_o,
	output logic [3:0] src_reg_o,
	output logic src_reg_valid_o,
	output op_decode_pkg::acc_t access_o,
	output logic [DATA_W-1:0] imm_o,
	output logic imm_valid_o,
	output logic [DATA_W-1:0] target_o,
	output logic target_valid_o
);
	import op_decode_pkg::*;

	// Target path needs room for the doubled displacement
	if (DATA_W < D12_W + BR_SHIFT) begin : g_width_check
		$error("decoder: DATA_W too small");
	end

	function automatic logic is_op(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] p);
		is_op = (w & m) == p;
	endfunction

	logic [3:0] field_reg;
	logic [7:0] field_imm;
	ext_t ext_kind;
	logic [DATA_W-1:0] imm_ext;

	logic valid_r, valid_nxt;
	fmt_t fmt_r, fmt_nxt;
	logic [3:0] dst_r, dst_nxt, src_r, src_nxt;
	logic dst_v_r, dst_v_nxt, src_v_r, src_v_nxt;
	acc_t acc_r, acc_nxt;
	logic [DATA_W-1:0] imm_r, imm_nxt, tgt_r, tgt_nxt;
	logic imm_v_r, imm_v_nxt, tgt_v_r, tgt_v_nxt;

	assign field_reg = instr_i[REG_HI:REG_LO];
	assign field_imm = instr_i[IMM_HI:0];

	imm_extend #(.DATA_W(DATA_W)) u_ext (
		.imm_i(field_imm),
		.kind_i(ext_kind),
		.value_o(imm_ext)
	);

	always_comb begin
		logic [DATA_W-1:0] d12;
		d12 = {{(DATA_W-D12_W){instr_i[D12_HI]}}, instr_i[D12_HI:0]};
		valid_nxt = valid_i;
		fmt_nxt = FMT_NONE;
		dst_nxt = 4'h0;
		src_nxt = 4'h0;
		dst_v_nxt = 1'b0;
		src_v_nxt = 1'b0;
		acc_nxt = ACC_DIRECT;
		ext_kind = EXT_NONE;
		imm_v_nxt = 1'b0;
		tgt_nxt = '0;
		tgt_v_nxt = 1'b0;
		// Opcode picks the format, the format picks the fields
		if (!valid_i) begin
			fmt_nxt = FMT_NONE;
		end else if (is_op(instr_i, MSK_D12, OPC_BRA) || is_op(instr_i, MSK_D12, OPC_BSR)) begin
			fmt_nxt = FMT_D12;
			tgt_nxt = pc_i + (d12 << BR_SHIFT);
			tgt_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_I8, OPC_TST) || is_op(instr_i, MSK_I8, OPC_AND)
			|| is_op(instr_i, MSK_I8, OPC_OR) || is_op(instr_i, MSK_I8, OPC_XOR)) begin
			fmt_nxt = FMT_I;
			ext_kind = EXT_ZERO;
			imm_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_I8, OPC_CMPEQ)) begin
			fmt_nxt = FMT_I;
			ext_kind = EXT_SIGN;
			imm_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_I8, OPC_TRAP)) begin
			fmt_nxt = FMT_I;
			ext_kind = EXT_TRAP;
			imm_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_NI, OPC_MOVI) || is_op(instr_i, MSK_NI, OPC_ADDI)) begin
			fmt_nxt = FMT_NI;
			ext_kind = EXT_SIGN;
			imm_v_nxt = 1'b1;
			dst_nxt = field_reg;
			dst_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_NM, OPC_MOVE_TBIT) || is_op(instr_i, MSK_NM, OPC_STS_MACH)) begin
			fmt_nxt = FMT_N;
			dst_nxt = field_reg;
			dst_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_NM, OPC_STCL_SR)) begin
			fmt_nxt = FMT_N;
			dst_nxt = field_reg;
			dst_v_nxt = 1'b1;
			acc_nxt = ACC_PREDEC;
		end else if (is_op(instr_i, MSK_NM, OPC_LDC_SR)) begin
			fmt_nxt = FMT_M;
			src_nxt = field_reg;
			src_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_NM, OPC_LDCL_SR)) begin
			fmt_nxt = FMT_M;
			src_nxt = field_reg;
			src_v_nxt = 1'b1;
			acc_nxt = ACC_POSTINC;
		end else if (is_op(instr_i, MSK_NM, OPC_JMP) || is_op(instr_i, MSK_NM, OPC_JSR)) begin
			fmt_nxt = FMT_M;
			src_nxt = field_reg;
			src_v_nxt = 1'b1;
			acc_nxt = ACC_INDIRECT;
			tgt_nxt = src_reg_val_i;
			tgt_v_nxt = 1'b1;
		end else if (is_op(instr_i, MSK_NM, OPC_BRANCH_FAR_REGISTER) || is_op(instr_i, MSK_NM, OPC_BSRF)) begin
			fmt_nxt = FMT_M;
			src_nxt = field_reg;
			src_v_nxt = 1'b1;
			tgt_nxt = pc_i + src_reg_val_i;
			tgt_v_nxt = 1'b1;
		end else if (instr_i == OPC_NOP || instr_i == OPC_RTS || instr_i == OPC_CLRT
			|| instr_i == OPC_SETT || instr_i == OPC_RTE) begin
			fmt_nxt = FMT_ZERO;
		end
		imm_nxt = imm_v_nxt ? imm_ext : '0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_r <= 1'b0;
			fmt_r <= FMT_NONE;
			dst_r <= 4'h0;
			src_r <= 4'h0;
			dst_v_r <= 1'b0;
			src_v_r <= 1'b0;
			acc_r <= ACC_DIRECT;
			imm_r <= '0;
			imm_v_r <= 1'b0;
			tgt_r <= '0;
			tgt_v_r <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
			fmt_r <= fmt_nxt;
			dst_r <= dst_nxt;
			src_r <= src_nxt;
			dst_v_r <= dst_v_nxt;
			src_v_r <= src_v_nxt;
			acc_r <= acc_nxt;
			imm_r <= imm_nxt;
			imm_v_r <= imm_v_nxt;
			tgt_r <= tgt_nxt;
			tgt_v_r <= tgt_v_nxt;
		end
	end

	assign valid_o = valid_r;
	assign fmt_o = fmt_r;
	assign dst_reg_o = dst_r;
	assign dst_reg_valid_o = dst_v_r;
	assign src_reg_o = src_r;
	assign src_reg_valid_o = src_v_r;
	assign access_o = acc_r;
	assign imm_o = imm_r;
	assign imm_valid_o = imm_v_r;
	assign target_o = tgt_r;
	assign target_valid_o = tgt_v_r;

	property p_d12_target;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && instr_i[15:12] == 4'ha) |=> target_valid_o
			&& target_o == $past(pc_i) + {{19{$past(instr_i[11])}}, $past(instr_i[11:0]), 1'b0};
	endproperty
	a_d12_target: assert property (p_d12_target) else $error("d12 target wrong");

	property p_branch_far_register_target;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && (instr_i & 16'hf0ff) == 16'h0023) |=>
			target_o == $past(pc_i) + $past(src_reg_val_i);
	endproperty
	a_branch_far_register_target: assert property (p_branch_far_register_target) else $error("register branch wrong");

	property p_zero_ext;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && instr_i[15:10] == 6'h32) |=> imm_o == {24'h0, $past(instr_i[7:0])};
	endproperty
	a_zero_ext: assert property (p_zero_ext) else $error("zero extend wrong");

	property p_sign_ext;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && instr_i[15:12] == 4'he) |=>
			imm_o == {{24{$past(instr_i[7])}}, $past(instr_i[7:0])} && dst_reg_o == $past(instr_i[11:8]);
	endproperty
	a_sign_ext: assert property (p_sign_ext) else $error("sign extend wrong");

	property p_trap;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && instr_i[15:8] == 8'hc3) |=> imm_o == {22'h0, $past(instr_i[7:0]), 2'h0};
	endproperty
	a_trap: assert property (p_trap) else $error("trap vector wrong");

	property p_fields_exclusive;
		@(posedge clk_i) disable iff (rst_i)
		!(dst_reg_valid_o && src_reg_valid_o) && (valid_o || fmt_o == FMT_NONE);
	endproperty
	a_fields_exclusive: assert property (p_fields_exclusive) else $error("fields clash");

	property p_predec;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && (instr_i & 16'hf0ff) == 16'h4003) |=>
			access_o == ACC_PREDEC && dst_reg_valid_o && dst_reg_o == $past(instr_i[11:8]);
	endproperty
	a_predec: assert property (p_predec) else $error("predec dest wrong");

	property p_postinc;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && (instr_i & 16'hf0ff) == 16'h4007) |=>
			access_o == ACC_POSTINC && src_reg_valid_o && src_reg_o == $past(instr_i[11:8]);
	endproperty
	a_postinc: assert property (p_postinc) else $error("postinc source wrong");

	property p_zero_fmt;
		@(posedge clk_i) disable iff (rst_i)
		(valid_i && instr_i == 16'h0009) |=> fmt_o == FMT_ZERO
			&& !dst_reg_valid_o && !src_reg_valid_o && !imm_valid_o && !target_valid_o;
	endproperty
	a_zero_fmt: assert property (p_zero_fmt) else $error("no-operand fields set");

	c_bra: cover property (@(posedge clk_i) disable iff (rst_i) fmt_o == FMT_D12);
	c_trap: cover property (@(posedge clk_i) disable iff (rst_i) valid_i && instr_i[15:8] == 8'hc3);
	c_branch_far_register: cover property (@(posedge clk_i) disable iff (rst_i) fmt_o == FMT_M && target_valid_o);
	c_nop: cover property (@(posedge clk_i) disable iff (rst_i) fmt_o == FMT_ZERO);
endmodule

// file: logic/op_decode_pkg.sv
// Holds field positions, opcode patterns and scale constants for the operand decoder.
// Assumes a 16-bit instruction word and a 32-bit register and address width.
package op_decode_pkg;
	localparam int WORD_W = 16;
	localparam int DATA_W = 32;
	localparam int REG_HI = 11;
	localparam int REG_LO = 8;
	localparam int IMM_HI = 7;
	localparam int D12_HI = 11;
	localparam int D12_W = 12;
	localparam int IMM_W = 8;
	localparam int BR_SHIFT = 1;
	localparam int TRAP_SHIFT = 2;
	// Opcode patterns, compared against the word with operand fields masked
	localparam logic [15:0] OPC_BRA = 16'ha000;
	localparam logic [15:0] OPC_BSR = 16'hb000;
	localparam logic [15:0] MSK_D12 = 16'hf000;
	localparam logic [15:0] MSK_I8 = 16'hff00;
	localparam logic [15:0] OPC_TST = 16'hc800;
	localparam logic [15:0] OPC_AND = 16'hc900;
	localparam logic [15:0] OPC_XOR = 16'hca00;
	localparam logic [15:0] OPC_OR = 16'hcb00;
	localparam logic [15:0] OPC_CMPEQ = 16'h8800;
	localparam logic [15:0] OPC_TRAP = 16'hc300;
	localparam logic [15:0] MSK_NI = 16'hf000;
	localparam logic [15:0] OPC_MOVI = 16'he000;
	localparam logic [15:0] OPC_ADDI = 16'h7000;
	localparam logic [15:0] MSK_NM = 16'hf0ff;
	localparam logic [15:0] OPC_BRANCH_FAR_REGISTER = 16'h0023;
	localparam logic [15:0] OPC_BSRF = 16'h0003;
	localparam logic [15:0] OPC_JMP = 16'h402b;
	localparam logic [15:0] OPC_JSR = 16'h400b;
	localparam logic [15:0] OPC_MOVE_TBIT = 16'h0029;
	localparam logic [15:0] OPC_STS_MACH = 16'h000a;
	localparam logic [15:0] OPC_STCL_SR = 16'h4003;
	localparam logic [15:0] OPC_LDC_SR = 16'h400e;
	localparam logic [15:0] OPC_LDCL_SR = 16'h4007;
	localparam logic [15:0] OPC_NOP = 16'h0009;
	localparam logic [15:0] OPC_RTS = 16'h000b;
	localparam logic [15:0] OPC_CLRT = 16'h0008;
	localparam logic [15:0] OPC_SETT = 16'h0018;
	localparam logic [15:0] OPC_RTE = 16'h002b;

	typedef enum logic [2:0] {
		FMT_NONE, FMT_ZERO, FMT_N, FMT_M, FMT_I, FMT_NI, FMT_D12
	} fmt_t;

	typedef enum logic [1:0] {
		ACC_DIRECT, ACC_PREDEC, ACC_POSTINC, ACC_INDIRECT
	} acc_t;

	typedef enum logic [1:0] {
		EXT_NONE, EXT_ZERO, EXT_SIGN, EXT_TRAP
	} ext_t;
endpackage

// file: logic/imm_extend.sv
// Holds the 8-bit immediate extender for the operand decoder.
// Assumes the extend kind is chosen by the caller from the opcode.
`timescale 1ns/1ps
module imm_extend #(
	parameter int DATA_W = 32
) (
	input wire logic [7:0] imm_i,
	input wire op_decode_pkg::ext_t kind_i,
	output logic [DATA_W-1:0] value_o
);
	import op_decode_pkg::*;

	// Refuse widths that leave no room for the extension bits
	if (DATA_W <= IMM_W + TRAP_SHIFT) begin : g_width_check
		$error("imm_extend: DATA_W too small");
	end

	always_comb begin
		case (kind_i)
			EXT_ZERO: value_o = {{(DATA_W-IMM_W){1'b0}}, imm_i};
			EXT_SIGN: value_o = {{(DATA_W-IMM_W){imm_i[IMM_W-1]}}, imm_i};
			EXT_TRAP: value_o = {{(DATA_W-IMM_W-TRAP_SHIFT){1'b0}}, imm_i, {TRAP_SHIFT{1'b0}}};
			default: value_o = '0;
		endcase
	end
endmodule

// file: sim/reg_file_model.sv
// Register file of the execute stage, as seen by the operand decoder.
// Assumes the decoder reads the register named by instr bits 11-8 in the same cycle.
`timescale 1ns/1ps
module reg_file_model (
	input wire logic [3:0] sel_i,
	input wire logic active_i,
	output logic [31:0] val_o
);
	// Inverse pattern when no instruction is offered, so stale data never looks valid
	assign val_o = active_i ? {4{sel_i, ~sel_i}} : ~{4{sel_i, ~sel_i}};
endmodule

// file: sim/operand_field_and_ea_decoder_test.sv
// Self-checking bench for the operand field and effective address decoder.
// Assumes one-cycle latency and the opcode patterns of the decoder package.
`timescale 1ns/1ps
module operand_field_and_ea_decoder_test;
	import op_decode_pkg::*;
	typedef struct packed {
		fmt_t fmt; logic [3:0] dst; logic dv; logic [3:0] src; logic sv; acc_t acc;
		logic [31:0] imm; logic iv; logic [31:0] tgt; logic tv;
	} exp_t;
	localparam logic [15:0] OPC [25] = '{OPC_BRA, OPC_BSR, OPC_TST, OPC_AND, OPC_XOR, OPC_OR,
		OPC_CMPEQ, OPC_MOVI, OPC_ADDI, OPC_TRAP, OPC_BRANCH_FAR_REGISTER, OPC_BSRF, OPC_JMP, OPC_JSR, OPC_MOVE_TBIT,
		OPC_STS_MACH, OPC_STCL_SR, OPC_LDC_SR, OPC_LDCL_SR, OPC_NOP, OPC_RTS, OPC_CLRT, OPC_SETT,
		OPC_RTE, 16'hffff};
	logic clk_i, rst_i, valid_i, valid_o, dst_reg_valid_o, src_reg_valid_o, imm_valid_o;
	logic target_valid_o, armed;
	logic [15:0] instr_i;
	logic [31:0] pc_i, src_reg_val_i, imm_o, target_o;
	logic [3:0] dst_reg_o, src_reg_o;
	fmt_t fmt_o;
	acc_t access_o;
	exp_t q[$];
	exp_t got;
	int n_errors, check_count;
	int seed;

	operand_field_and_ea_decoder #(.DATA_W(32)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.valid_i(valid_i), .instr_i(instr_i), .pc_i(pc_i), .src_reg_val_i(src_reg_val_i),
		.valid_o(valid_o), .fmt_o(fmt_o), .dst_reg_o(dst_reg_o),
		.dst_reg_valid_o(dst_reg_valid_o), .src_reg_o(src_reg_o),
		.src_reg_valid_o(src_reg_valid_o), .access_o(access_o), .imm_o(imm_o),
		.imm_valid_o(imm_valid_o), .target_o(target_o), .target_valid_o(target_valid_o));
	reg_file_model i_regs (.sel_i(instr_i[11:8]), .active_i(valid_i), .val_o(src_reg_val_i));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Issue one instruction of class c and note what it must decode to
	task issue(input int c, input int rep);
		logic [3:0] n;
		logic [7:0] i;
		logic [11:0] d;
		logic [31:0] pc, r;
		logic [15:0] w;
		exp_t e;
		n = 4'($random(seed));
		i = (rep == 0) ? 8'h80 : (rep == 1) ? 8'h7f : 8'($random(seed));
		d = (rep == 0) ? 12'h800 : (rep == 1) ? 12'h7ff : 12'($random(seed));
		pc = $random(seed);
		r = {4{n, ~n}};
		e = '0;
		w = OPC[c];
		if (c < 2) begin
			w = w | {4'h0, d};
			e.fmt = FMT_D12;
			e.tv = 1'b1;
			e.tgt = pc + {{19{d[11]}}, d, 1'b0};
		end else if (c < 10) begin
			w = w | ((c == 7 || c == 8) ? {4'h0, n, i} : {8'h0, i});
			e.fmt = (c == 7 || c == 8) ? FMT_NI : FMT_I;
			e.iv = 1'b1;
			e.dv = (c == 7 || c == 8);
			e.dst = n;
			e.imm = (c < 6) ? {24'h0, i} : (c == 9) ? {22'h0, i, 2'b00} : {{24{i[7]}}, i};
		end else if (c < 19) begin
			w = w | {4'h0, n, 8'h0};
			e.fmt = (c == 14 || c == 15 || c == 16) ? FMT_N : FMT_M;
			e.dv = (e.fmt == FMT_N);
			e.dst = n;
			e.sv = (e.fmt == FMT_M);
			e.src = n;
			e.tv = (c < 14);
			e.tgt = (c < 12) ? pc + r : r;
			// Register branches only offset the PC; jumps go through the register
			e.acc = (c == 12 || c == 13) ? ACC_INDIRECT : (c == 16) ? ACC_PREDEC
				: (c == 18) ? ACC_POSTINC : ACC_DIRECT;
		end else begin
			e.fmt = (c < 24) ? FMT_ZERO : FMT_NONE;
		end
		@(negedge clk_i);
		valid_i = 1'b1;
		instr_i = w;
		pc_i = pc;
		q.push_back(e);
	endtask

	task idle(input int cycles);
		repeat (cycles) begin
			@(negedge clk_i);
			valid_i = 1'b0;
			instr_i = 16'($random(seed));
			pc_i = $random(seed);
		end
	endtask

	always @(negedge clk_i) begin
		if (armed) begin
			if (valid_o === 1'b1) begin
				if (q.size() == 0)
					check("queue", 1, 0);
				else begin
					got = q.pop_front();
					check("fmt", fmt_o, got.fmt);
					check("flags", {dst_reg_valid_o, src_reg_valid_o, imm_valid_o, target_valid_o},
						{got.dv, got.sv, got.iv, got.tv});
					check("imm", imm_o, got.imm);
					if (got.dv) check("dst", dst_reg_o, got.dst);
					if (got.sv) check("src", src_reg_o, got.src);
					check("access", access_o, got.acc);
					if (got.tv) check("target", target_o, got.tgt);
				end
			end else
				check("idle", {fmt_o, dst_reg_valid_o, src_reg_valid_o, imm_valid_o,
					target_valid_o, valid_o}, 0);
		end
	end

	initial begin
		clk_i = 0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		#400000;
		n_errors++;
		complete_run();
	end

	initial begin
		seed = 32'hde92;
		armed = 1'b0;
		rst_i = 1'b1;
		valid_i = 1'b0;
		instr_i = '0;
		pc_i = '0;
		n_errors = 0;
		check_count = 0;
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		armed = 1'b1;
		for (int rep = 0; rep < 12; rep++)
			for (int c = 0; c < 25; c++) begin
				issue(c, rep);
				if (rep[0] && c[2]) idle(1);
			end
		idle(3);
		rst_i = 1'b1;
		issue(7, 5);
		void'(q.pop_back());
		idle(2);
		rst_i = 1'b0;
		for (int c = 0; c < 25; c++) issue(c, 3);
		idle(3);
		check("leftover", q.size(), 0);
		complete_run();
	end
endmodule
